// ---- hw/attr_bank.sv ----
`timescale 1ns/1ps
// One attribute group of the window RAM; separate banks give per-group write
// enables, so masked groups keep their value without a read-modify-write.
module attr_bank #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 2048,
  parameter int AW    = 11
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// ---- hw/osd_text_pkg.sv ----
// Contract
// - Low three filter bits choose which property registers must be refreshed.
// - Commit word and advance cursor once all active registers were written, unless a fill is running.
// - Inactive property registers still contribute their held value to commits.
// - Mode 000 never commits; single-bit modes commit on every write to their one active register.
// - Pointer steps high, mid, low through active registers, then wraps.
// - Mode 001: each low register write creates one new element, except while a fill runs.
// - Filter bits decide which attribute groups are stored per element.
// - A cleared filter bit keeps that group's stored value untouched.
// - Bit 7 gates flashing style, bit 6 gates drop outline.
// - Bit 5 gates see-through, blend and tint of the background.
// - Bit 4 gates see-through, blend and tint of the foreground.
// - Bit 3 gates ROM select and the nine-bit glyph index.
// - Fill rectangle corners are held in four registers.
// - Writing 1 to the fill start bit fills the rectangle when its corners are ordered and inside the window.
// - Area fill still honours the attribute filter bits.
// - Elements hold attributes plus glyph index; glyph fetched from ROM or RAM.
// - Cursor moves right, wraps to next line, readable at any time.
// - Each element stores 23 property bits.
// - ROM select 1 picks the fixed store, 0 picks font RAM.
package osd_text_pkg;
  localparam logic [7:0] ADDR_CTRL0    = 8'h00;
  localparam logic [7:0] ADDR_FILTER   = 8'h01;
  localparam logic [7:0] ADDR_HIGH     = 8'h02;
  localparam logic [7:0] ADDR_MID      = 8'h03;
  localparam logic [7:0] ADDR_LOW      = 8'h04;
  localparam logic [7:0] ADDR_CUR_COL  = 8'h05;
  localparam logic [7:0] ADDR_CUR_ROW  = 8'h06;
  localparam logic [7:0] ADDR_FILL_L   = 8'h07;
  localparam logic [7:0] ADDR_FILL_T   = 8'h08;
  localparam logic [7:0] ADDR_FILL_R   = 8'h09;
  localparam logic [7:0] ADDR_FILL_B   = 8'h0a;

  localparam int         CTRL0_FILL_BIT = 0;
  localparam int         MODE_MSB       = 2;
  localparam logic [2:0] MODE_NONE      = 3'b000;
  localparam logic [7:0] FILTER_RST     = 8'hf8;
  localparam logic [7:0] REG_RST        = 8'h00;

  localparam int PI_LOW  = 0;
  localparam int PI_MID  = 1;
  localparam int PI_HIGH = 2;
  localparam int PI_NONE = 3;

  localparam int WORD_W          = 23;
  localparam int W_FLASH_MSB     = 22;
  localparam int W_FLASH_LSB     = 21;
  localparam int W_OUTLINE       = 20;
  localparam int W_BACK_SEE      = 19;
  localparam int W_FORE_SEE      = 18;
  localparam int W_BACK_BLEND    = 17;
  localparam int W_FORE_BLEND    = 16;
  localparam int W_BACK_TINT_MSB = 15;
  localparam int W_BACK_TINT_LSB = 13;
  localparam int W_FORE_TINT_MSB = 12;
  localparam int W_FORE_TINT_LSB = 10;
  localparam int W_ROM_SEL       = 9;
  localparam int W_GLYPH_MSB     = 8;

  localparam int GRP_COUNT   = 5;
  localparam int GRP_MAX_W   = 10;
  localparam int GRP_FLASH   = 0;
  localparam int GRP_OUTLINE = 1;
  localparam int GRP_BACK    = 2;
  localparam int GRP_FORE    = 3;
  localparam int GRP_GLYPH   = 4;
  localparam int GRP_W        [GRP_COUNT] = '{2, 1, 5, 5, 10};
  localparam int GRP_MASK_BIT [GRP_COUNT] = '{7, 6, 5, 4, 3};

  typedef enum logic [1:0] {
    FILL_IDLE = 2'b00,
    FILL_RUN  = 2'b01
  } fill_state_t;

  function automatic logic [GRP_MAX_W-1:0] group_slice(input int g, input logic [WORD_W-1:0] w);
    logic [GRP_MAX_W-1:0] s;
    s = '0;
    case (g)
      GRP_FLASH:   s = {8'h00, w[W_FLASH_MSB:W_FLASH_LSB]};
      GRP_OUTLINE: s = {9'h000, w[W_OUTLINE]};
      GRP_BACK:    s = {5'h00, w[W_BACK_SEE], w[W_BACK_BLEND], w[W_BACK_TINT_MSB:W_BACK_TINT_LSB]};
      GRP_FORE:    s = {5'h00, w[W_FORE_SEE], w[W_FORE_BLEND], w[W_FORE_TINT_MSB:W_FORE_TINT_LSB]};
      GRP_GLYPH:   s = w[W_ROM_SEL:0];
      default:     s = '0;
    endcase
    return s;
  endfunction
endpackage

// ---- hw/osd_text_window_writer.sv ----
`timescale 1ns/1ps
module osd_text_window_writer
  import osd_text_pkg::*;
#(
  parameter int COLS = 64,
  parameter int ROWS = 32,
  parameter int CW   = $clog2(COLS),
  parameter int RW   = $clog2(ROWS),
  parameter int AW   = $clog2(COLS * ROWS)
) (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              addr_load,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  input  wire logic [7:0]        wdata,
  output logic      [7:0]        rdata,
  output logic                   rdata_valid,
  output logic                   fill_busy,
  output logic                   elem_commit,
  input  wire logic [CW-1:0]     disp_col,
  input  wire logic [RW-1:0]     disp_row,
  output logic      [WORD_W-1:0] elem_word,
  output logic                   glyph_from_rom,
  output logic      [8:0]        glyph_index
);
  logic [7:0]    filter_r;
  logic [6:0]    high_r;
  logic [7:0]    mid_r;
  logic [7:0]    low_r;
  logic [CW-1:0] cur_col_r;
  logic [RW-1:0] cur_row_r;
  logic [7:0]    fill_l_r;
  logic [7:0]    fill_t_r;
  logic [7:0]    fill_r_r;
  logic [7:0]    fill_b_r;
  logic [7:0]    ptr_r;
  logic [2:0]    pending_r;
  logic          commit_r;
  fill_state_t   fill_state_r;
  logic [CW-1:0] fc_r;
  logic [RW-1:0] fr_r;
  logic [7:0]    rdata_r;
  logic          rdata_valid_r;

  function automatic int prop_index(input logic [7:0] a);
    case (a)
      ADDR_HIGH: return PI_HIGH;
      ADDR_MID:  return PI_MID;
      ADDR_LOW:  return PI_LOW;
      default:   return PI_NONE;
    endcase
  endfunction

  // Descending walk through active registers; inactive or other targets count up
  function automatic logic [7:0] next_ptr(input logic [7:0] p, input logic [2:0] m);
    logic [7:0] n;
    n = p + 8'h01;
    case (p)
      ADDR_HIGH: if (m[PI_HIGH]) n = m[PI_MID] ? ADDR_MID  : (m[PI_LOW]  ? ADDR_LOW  : ADDR_HIGH);
      ADDR_MID:  if (m[PI_MID])  n = m[PI_LOW] ? ADDR_LOW  : (m[PI_HIGH] ? ADDR_HIGH : ADDR_MID);
      ADDR_LOW:  if (m[PI_LOW])  n = m[PI_HIGH] ? ADDR_HIGH : (m[PI_MID] ? ADDR_MID  : ADDR_LOW);
      default:   n = p + 8'h01;
    endcase
    return n;
  endfunction

  function automatic logic [AW-1:0] elem_addr(input logic [CW-1:0] c, input logic [RW-1:0] r);
    return AW'(r * COLS + c);
  endfunction

  logic [2:0]  mode;
  logic        host_wr;
  logic        host_rd;
  int          pi;
  logic [2:0]  pbit;
  logic        prop_hit;
  logic        all_done;
  logic        fill_run;
  logic        wr_go;
  logic        cur_wr;
  logic        fill_ok;
  logic        fill_last;
  logic [AW-1:0] wr_addr;
  logic [WORD_W-1:0] prop_word;

  assign mode      = filter_r[MODE_MSB:0];
  assign host_wr   = wr_en && !addr_load;
  assign host_rd   = rd_en && !addr_load && !wr_en;
  assign pi        = prop_index(ptr_r);
  assign pbit      = (pi == PI_NONE) ? 3'b000 : 3'(3'b001 << pi);
  assign prop_hit  = host_wr && ((pbit & mode) != 3'b000);
  assign all_done  = (((pending_r | pbit) & mode) == mode);
  assign fill_run  = (fill_state_r == FILL_RUN);
  assign cur_wr    = commit_r && !fill_run;
  assign wr_go     = cur_wr || fill_run;
  assign wr_addr   = fill_run ? elem_addr(fc_r, fr_r) : elem_addr(cur_col_r, cur_row_r);
  // Held registers always make up the whole word
  assign prop_word = {high_r, mid_r, low_r};
  assign fill_ok   = (fill_l_r <= fill_r_r) && (fill_t_r <= fill_b_r) &&
                     (32'(fill_r_r) < COLS) && (32'(fill_b_r) < ROWS);
  assign fill_last = (32'(fc_r) == 32'(fill_r_r)) && (32'(fr_r) == 32'(fill_b_r));

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ptr_r <= REG_RST;
    end else if (addr_load) begin
      ptr_r <= wdata;
    end else if (host_wr || host_rd) begin
      ptr_r <= next_ptr(ptr_r, mode);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      filter_r <= FILTER_RST;
      high_r   <= REG_RST[6:0];
      mid_r    <= REG_RST;
      low_r    <= REG_RST;
      fill_l_r <= REG_RST;
      fill_t_r <= REG_RST;
      fill_r_r <= REG_RST;
      fill_b_r <= REG_RST;
    end else if (host_wr) begin
      case (ptr_r)
        ADDR_FILTER: filter_r <= wdata;
        ADDR_HIGH:   high_r   <= wdata[6:0];
        ADDR_MID:    mid_r    <= wdata;
        ADDR_LOW:    low_r    <= wdata;
        ADDR_FILL_L: fill_l_r <= wdata;
        ADDR_FILL_T: fill_t_r <= wdata;
        ADDR_FILL_R: fill_r_r <= wdata;
        ADDR_FILL_B: fill_b_r <= wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pending_r <= 3'b000;
    end else if (addr_load || (host_wr && ptr_r == ADDR_FILTER)) begin
      pending_r <= 3'b000;
    end else if (prop_hit) begin
      pending_r <= all_done ? 3'b000 : ((pending_r | pbit) & mode);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      commit_r <= 1'b0;
    end else begin
      commit_r <= prop_hit && all_done;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      elem_commit <= 1'b0;
    end else begin
      elem_commit <= cur_wr;
    end
  end

  // Host cursor writes win over a same-cycle advance
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cur_col_r <= '0;
      cur_row_r <= '0;
    end else if (host_wr && ptr_r == ADDR_CUR_COL) begin
      cur_col_r <= wdata[CW-1:0];
    end else if (host_wr && ptr_r == ADDR_CUR_ROW) begin
      cur_row_r <= wdata[RW-1:0];
    end else if (cur_wr) begin
      if (32'(cur_col_r) == COLS - 1) begin
        cur_col_r <= '0;
        cur_row_r <= (32'(cur_row_r) == ROWS - 1) ? '0 : RW'(cur_row_r + 1'b1);
      end else begin
        cur_col_r <= CW'(cur_col_r + 1'b1);
      end
    end
  end

  // One element per cycle, row by row
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fill_state_r <= FILL_IDLE;
      fc_r         <= '0;
      fr_r         <= '0;
    end else begin
      case (fill_state_r)
        FILL_IDLE: begin
          if (host_wr && ptr_r == ADDR_CTRL0 && wdata[CTRL0_FILL_BIT] && fill_ok) begin
            fill_state_r <= FILL_RUN;
            fc_r         <= fill_l_r[CW-1:0];
            fr_r         <= fill_t_r[RW-1:0];
          end
        end
        FILL_RUN: begin
          if (fill_last) begin
            fill_state_r <= FILL_IDLE;
          end else if (32'(fc_r) == 32'(fill_r_r)) begin
            fc_r <= fill_l_r[CW-1:0];
            fr_r <= RW'(fr_r + 1'b1);
          end else begin
            fc_r <= CW'(fc_r + 1'b1);
          end
        end
        default: fill_state_r <= FILL_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fill_busy <= 1'b0;
    end else begin
      fill_busy <= (fill_state_r == FILL_RUN) && !fill_last ||
                   (fill_state_r == FILL_IDLE) && host_wr && ptr_r == ADDR_CTRL0 &&
                   wdata[CTRL0_FILL_BIT] && fill_ok;
    end
  end

  // Reads return the register under the pointer; cursor is always readable
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdata_r       <= 8'h00;
      rdata_valid_r <= 1'b0;
    end else begin
      rdata_valid_r <= host_rd;
      if (host_rd) begin
        case (ptr_r)
          ADDR_CTRL0:   rdata_r <= {7'h00, fill_run};
          ADDR_FILTER:  rdata_r <= filter_r;
          ADDR_HIGH:    rdata_r <= {1'b0, high_r};
          ADDR_MID:     rdata_r <= mid_r;
          ADDR_LOW:     rdata_r <= low_r;
          ADDR_CUR_COL: rdata_r <= 8'(cur_col_r);
          ADDR_CUR_ROW: rdata_r <= 8'(cur_row_r);
          ADDR_FILL_L:  rdata_r <= fill_l_r;
          ADDR_FILL_T:  rdata_r <= fill_t_r;
          ADDR_FILL_R:  rdata_r <= fill_r_r;
          ADDR_FILL_B:  rdata_r <= fill_b_r;
          default:      rdata_r <= 8'h00;
        endcase
      end
    end
  end

  assign rdata       = rdata_r;
  assign rdata_valid = rdata_valid_r;

  logic [GRP_MAX_W-1:0] grp_q  [GRP_COUNT];
  logic [GRP_COUNT-1:0] grp_we;

  generate
    for (genvar g = 0; g < GRP_COUNT; g++) begin : g_bank
      logic [GRP_MAX_W-1:0] slice;
      assign slice     = group_slice(g, prop_word);
      // Masked group bank is simply not written, so it keeps its old value
      assign grp_we[g] = wr_go && filter_r[GRP_MASK_BIT[g]];
      attr_bank #(
        .WIDTH (GRP_W[g]),
        .DEPTH (COLS * ROWS),
        .AW    (AW)
      ) u_bank (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .wr_en   (grp_we[g]),
        .wr_addr (wr_addr),
        .wr_data (slice[GRP_W[g]-1:0]),
        .rd_addr (elem_addr(disp_col, disp_row)),
        .rd_data (grp_q[g][GRP_W[g]-1:0])
      );
      if (GRP_W[g] < GRP_MAX_W) begin : g_pad
        assign grp_q[g][GRP_MAX_W-1:GRP_W[g]] = '0;
      end
    end
  endgenerate

  // Groups: flash bit 7, outline bit 6, back bit 5, fore bit 4, glyph bit 3
  assign elem_word = {grp_q[GRP_FLASH][1:0], grp_q[GRP_OUTLINE][0],
                      grp_q[GRP_BACK][4], grp_q[GRP_FORE][4],
                      grp_q[GRP_BACK][3], grp_q[GRP_FORE][3],
                      grp_q[GRP_BACK][2:0], grp_q[GRP_FORE][2:0],
                      grp_q[GRP_GLYPH][9:0]};
  assign glyph_from_rom = grp_q[GRP_GLYPH][W_ROM_SEL];
  assign glyph_index    = grp_q[GRP_GLYPH][W_GLYPH_MSB:0];

  sequence s_low_write_mode1;
    host_wr && ptr_r == ADDR_LOW && mode == 3'b001;
  endsequence

  sequence s_fill_launch;
    fill_state_r == FILL_IDLE && host_wr && ptr_r == ADDR_CTRL0 && wdata[0] && fill_ok;
  endsequence

  property p_mode1_commit;
    @(posedge ref_clk) disable iff (!resetn)
      s_low_write_mode1 ##1 !fill_run |-> commit_r ##1 elem_commit;
  endproperty
  a_mode1_commit: assert property (p_mode1_commit) else $error("mode 001 low write lost");

  property p_mode_none;
    @(posedge ref_clk) disable iff (!resetn)
      (host_wr && mode == MODE_NONE && ptr_r != ADDR_FILTER) |=> !commit_r;
  endproperty
  a_mode_none: assert property (p_mode_none) else $error("commit in mode 000");

  property p_burst_order;
    @(posedge ref_clk) disable iff (!resetn)
      (host_wr && ptr_r == ADDR_HIGH && mode == 3'b111) |=> (ptr_r == ADDR_MID);
  endproperty
  a_burst_order: assert property (p_burst_order) else $error("burst order wrong");

  property p_cursor_step;
    @(posedge ref_clk) disable iff (!resetn)
      (cur_wr && !host_wr && 32'(cur_col_r) < COLS - 1)
        |=> (cur_col_r == CW'($past(cur_col_r) + 1'b1)) && $stable(cur_row_r);
  endproperty
  a_cursor_step: assert property (p_cursor_step) else $error("cursor did not step");

  property p_fill_start;
    @(posedge ref_clk) disable iff (!resetn)
      s_fill_launch |=> fill_run && fc_r == fill_l_r[CW-1:0] && fr_r == fill_t_r[RW-1:0];
  endproperty
  a_fill_start: assert property (p_fill_start) else $error("fill not started");

  property p_fill_end;
    @(posedge ref_clk) disable iff (!resetn)
      (fill_run && fill_last) |=> !fill_run && !fill_busy;
  endproperty
  a_fill_end: assert property (p_fill_end) else $error("fill did not end");

  property p_no_commit_in_fill;
    @(posedge ref_clk) disable iff (!resetn)
      (commit_r && fill_run && !host_wr) |=> $stable(cur_col_r) && !elem_commit;
  endproperty
  a_no_commit_in_fill: assert property (p_no_commit_in_fill) else $error("commit in fill");

  property p_seq_restart;
    @(posedge ref_clk) disable iff (!resetn)
      addr_load |=> pending_r == 3'b000;
  endproperty
  a_seq_restart: assert property (p_seq_restart) else $error("sequence not restarted");

  property p_mask_glyph;
    @(posedge ref_clk) disable iff (!resetn)
      (fill_run && !filter_r[3]) |-> !grp_we[GRP_GLYPH] && grp_we[GRP_FLASH] == filter_r[7];
  endproperty
  a_mask_glyph: assert property (p_mask_glyph) else $error("fill ignored filter");
endmodule

// ---- verif/osd_host_model.sv ----
`timescale 1ns/1ps
module osd_host_model (
  input  wire logic       ref_clk,
  output logic            addr_load,
  output logic            wr_en,
  output logic            rd_en,
  output logic      [7:0] wdata,
  input  wire logic [7:0] rdata,
  input  wire logic       rdata_valid
);
  initial begin
    addr_load = 1'b0;
    wr_en     = 1'b0;
    rd_en     = 1'b0;
    wdata     = 8'h5a;
  end

  task automatic pick(input logic [7:0] a);
    @(negedge ref_clk);
    addr_load = 1'b1;
    wdata     = a;
  endtask

  // Bytes go back to back; the released byte is inverted so it never looks fresh
  task automatic wr_burst(input logic [7:0] a, input int n, input logic [7:0] d [8]);
    pick(a);
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      addr_load = 1'b0;
      wr_en     = 1'b1;
      wdata     = d[i];
    end
    @(negedge ref_clk);
    wr_en = 1'b0;
    wdata = ~wdata;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    pick(a);
    @(negedge ref_clk);
    addr_load = 1'b0;
    rd_en     = 1'b1;
    wdata     = ~a;
    @(negedge ref_clk);
    rd_en = 1'b0;
    v     = rdata_valid;
    d     = rdata;
  endtask
endmodule

// ---- verif/osd_text_window_writer_tb.sv ----
`timescale 1ns/1ps
module osd_text_window_writer_tb;
  import osd_text_pkg::*;
  localparam int COLS = 8;
  localparam int ROWS = 4;
  localparam int CW   = $clog2(COLS);
  localparam int RW   = $clog2(ROWS);
  logic              ref_clk, resetn, addr_load, wr_en, rd_en;
  logic              rdata_valid, fill_busy, elem_commit, glyph_from_rom;
  logic [7:0]        wdata, rdata, filt;
  logic [8:0]        glyph_index;
  logic [CW-1:0]     disp_col;
  logic [RW-1:0]     disp_row;
  logic [WORD_W-1:0] elem_word;
  logic [WORD_W-1:0] model [COLS*ROWS];
  logic [7:0]        props [3];
  logic [7:0]        d [8];
  int                bad_count, num_checks, commits, busy_cyc, c0, k, r0;

  osd_host_model osd_host_model_i (
    .ref_clk(ref_clk), .addr_load(addr_load), .wr_en(wr_en), .rd_en(rd_en),
    .wdata(wdata), .rdata(rdata), .rdata_valid(rdata_valid)
  );

  osd_text_window_writer #(.COLS(COLS), .ROWS(ROWS)) osd_text_window_writer_i (
    .ref_clk(ref_clk), .resetn(resetn), .addr_load(addr_load), .wr_en(wr_en),
    .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .rdata_valid(rdata_valid),
    .fill_busy(fill_busy), .elem_commit(elem_commit), .disp_col(disp_col),
    .disp_row(disp_row), .elem_word(elem_word), .glyph_from_rom(glyph_from_rom),
    .glyph_index(glyph_index)
  );

  // Counted at the falling edge, where registered outputs have settled
  always @(negedge ref_clk) begin
    if (elem_commit === 1'b1)
      commits++;
    if (fill_busy === 1'b1)
      busy_cyc++;
  end

  function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] o,
                                              input logic [WORD_W-1:0] n, input logic [7:0] f);
    logic [WORD_W-1:0] m;
    m = {{2{f[7]}}, f[6], f[5], f[4], f[5], f[4], {3{f[5]}}, {3{f[4]}}, {10{f[3]}}};
    return (n & m) | (o & ~m);
  endfunction

  task automatic stop_test;
    $display("checks=%0d errors=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr1(input logic [7:0] a, input logic [7:0] v);
    d[0] = v;
    osd_host_model_i.wr_burst(a, 1, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    logic       ok;
    osd_host_model_i.rd(a, v, ok);
    chk(32'(ok), 32'h1);
    chk(32'(v), 32'(exp));
  endtask

  task automatic peek(input int c, input int r);
    logic [WORD_W-1:0] w;
    w = model[r*COLS+c];
    @(negedge ref_clk);
    disp_col = CW'(c);
    disp_row = RW'(r);
    @(negedge ref_clk);
    chk(32'(elem_word), 32'(w));
    chk(32'({glyph_from_rom, glyph_index}), 32'(w[9:0]));
  endtask

  // Poke variant reads the start bit and sends a low-register write mid-fill
  task automatic fill(input int l, input int t, input int r, input int b, input bit poke);
    d = '{8'(l), 8'(t), 8'(r), 8'(b), 8'h00, 8'h00, 8'h00, 8'h00};
    osd_host_model_i.wr_burst(ADDR_FILL_L, 4, d);
    busy_cyc = 0;
    wr1(ADDR_CTRL0, 8'h01);
    if (poke) begin
      rdchk(ADDR_CTRL0, 8'h01);
      wr1(ADDR_LOW, props[0]);
    end
    for (int i = 0; i < 200 && fill_busy === 1'b1; i++)
      @(negedge ref_clk);
    chk(32'(fill_busy), 32'h0);
    chk(32'(busy_cyc), 32'((r - l + 1) * (b - t + 1)));
    for (int y = t; y <= b; y++)
      for (int x = l; x <= r; x++) begin
        model[y*COLS+x] = merge(model[y*COLS+x], {props[2][6:0], props[1], props[0]}, filt);
        peek(x, y);
      end
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    #400000;
    bad_count++;
    stop_test;
  end

  initial begin
    resetn     = 1'b0;
    disp_col   = '0;
    disp_row   = '0;
    bad_count  = 0;
    num_checks = 0;
    commits    = 0;
    void'($urandom(32'h4d91469b));
    repeat (20) @(negedge ref_clk);
    resetn = 1'b1;
    rdchk(ADDR_FILTER, FILTER_RST);
    rdchk(ADDR_CTRL0, 8'h00);
    rdchk(ADDR_CUR_ROW, 8'h00);
    wr1(8'h20, 8'hff);
    rdchk(8'h20, 8'h00);
    // Mode stays 000 while properties change ahead of the fill
    filt = FILTER_RST;
    for (int g = 0; g < 3; g++)
      props[g] = 8'($urandom);
    d = '{props[2], props[1], props[0], 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    osd_host_model_i.wr_burst(ADDR_HIGH, 3, d);
    fill(0, 0, COLS - 1, ROWS - 1, 1'b0);
    for (int m = 0; m < 8; m++) begin
      filt = {5'($urandom), 3'(m)};
      wr1(ADDR_FILTER, filt);
      r0 = m % ROWS;
      d[0] = 8'(COLS - 1);
      d[1] = 8'(r0);
      osd_host_model_i.wr_burst(ADDR_CUR_COL, 2, d);
      k = 0;
      for (int e = 0; e < 2; e++) begin
        for (int g = 2; g >= 0; g--)
          if (m[g]) begin
            props[g] = 8'($urandom);
            d[k]     = props[g];
            k++;
          end
        if (k != 0)
          model[(e == 0) ? r0*COLS+COLS-1 : ((r0+1)%ROWS)*COLS] =
            merge(model[(e == 0) ? r0*COLS+COLS-1 : ((r0+1)%ROWS)*COLS],
                  {props[2][6:0], props[1], props[0]}, filt);
      end
      if (k == 0)
        for (int g = 0; g < 3; g++) begin
          props[2-g] = 8'($urandom);
          d[g]       = props[2-g];
        end
      c0 = commits;
      // Mode 000 sends all three from the top so the cursor registers stay untouched
      osd_host_model_i.wr_burst((m[2] || k == 0) ? ADDR_HIGH : m[1] ? ADDR_MID : ADDR_LOW,
                                (k != 0) ? k : 3, d);
      repeat (3) @(negedge ref_clk);
      chk(32'(commits - c0), (k != 0) ? 32'h2 : 32'h0);
      rdchk(ADDR_CUR_COL, (k != 0) ? 8'h01 : 8'(COLS - 1));
      rdchk(ADDR_CUR_ROW, (k != 0) ? 8'((r0 + 1) % ROWS) : 8'(r0));
      peek(COLS - 1, r0);
      peek(0, (r0 + 1) % ROWS);
    end
    filt = {5'($urandom), 3'b001};
    wr1(ADDR_FILTER, filt);
    d[0] = 8'h02;
    d[1] = 8'h01;
    osd_host_model_i.wr_burst(ADDR_CUR_COL, 2, d);
    c0 = commits;
    fill(1, 1, 4, ROWS - 1, 1'b1);
    chk(32'(commits - c0), 32'h0);
    rdchk(ADDR_CUR_COL, 8'h02);
    d = '{8'h05, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    osd_host_model_i.wr_burst(ADDR_FILL_L, 4, d);
    wr1(ADDR_CTRL0, 8'h01);
    chk(32'(fill_busy), 32'h0);
    rdchk(ADDR_CTRL0, 8'h00);
    stop_test;
  end
endmodule
